// File: tccr_params.svh
// constants of the timer counter, prescaler and compare value registers
`ifndef TCCR_PARAMS_SVH
`define TCCR_PARAMS_SVH

// register byte offsets
`define TCCR_OFS_COUNTER 8'h24
`define TCCR_OFS_PRESCALER 8'h28
`define TCCR_OFS_RELOAD 8'h2c
`define TCCR_OFS_CH0_VALUE 8'h34
`define TCCR_OFS_CH1_VALUE 8'h38
`define TCCR_OFS_CHAN_CTRL 8'h80
`define TCCR_OFS_WR_FILTER 8'hfc

// field positions
`define TCCR_BIT_EQUAL_SKIP 1
`define TCCR_BIT_COUNT_EN 8
`define TCCR_CH_CTRL_STRIDE 4
`define TCCR_BIT_CH_INPUT 0
`define TCCR_BIT_CH_ENABLE 1
`define TCCR_BIT_CH_SHADOW 2

// reset values
`define TCCR_RST_VALUE16 16'h0000
`define TCCR_RST_WORD 32'h0000_0000

// bus encodings
`define TCCR_HSIZE_WORD 3'h2

`endif

// File: tccr_pkg.sv
// types shared by the timer register slice
`default_nettype none
package tccr_pkg;

  // data phase state of the bus slave
  typedef enum logic [2:0] {
    TCCR_ST_IDLE  = 3'b001,
    TCCR_ST_WRITE = 3'b010,
    TCCR_ST_READ  = 3'b100
  } tccr_bus_state_t;

endpackage
`default_nettype wire

// File: tccr_prescaler.sv
// counter clock prescaler with shadowed divide value
`timescale 1ns/10ps
`default_nettype none
`include "tccr_params.svh"
module tccr_prescaler #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic update_i,
  input wire logic [WIDTH-1:0] divide_i,
  // counter tick
  output logic tick_o
);
  logic [WIDTH-1:0] shadow_q;
  logic [WIDTH-1:0] div_q;

  assign tick_o = run_i && (div_q == shadow_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow_q <= '0;
    end else if (update_i) begin
      shadow_q <= divide_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || update_i) begin
      div_q <= '0;
    end else if (run_i) begin
      div_q <= tick_o ? '0 : div_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: tccr_channel.sv
// one capture/compare channel value with compare shadow
`timescale 1ns/10ps
`default_nettype none
`include "tccr_params.svh"
module tccr_channel #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic input_mode_i,
  input wire logic enable_i,
  input wire logic shadow_en_i,
  input wire logic equal_skip_i,
  // events and data
  input wire logic capture_i,
  input wire logic update_i,
  input wire logic write_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [WIDTH-1:0] count_i,
  // results
  output logic [WIDTH-1:0] value_o,
  output logic match_o
);
  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] shadow_q;
  logic write_ok;

  assign write_ok = write_i && !input_mode_i &&
    !(equal_skip_i && (wdata_i == value_q));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_q <= '0;
    end else if (input_mode_i) begin
      if (enable_i && capture_i) begin
        value_q <= count_i;
      end
    end else if (write_ok) begin
      value_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow_q <= '0;
    end else if (update_i) begin
      shadow_q <= value_q;
    end
  end

  assign value_o = value_q;
  assign match_o = !input_mode_i &&
    (count_i == (shadow_en_i ? shadow_q : value_q));
endmodule
`default_nettype wire

// File: tccr_top.sv
// timer counter, prescaler, reload and channel value registers on ahb-lite
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tccr_params.svh"
module tccr_top
  import tccr_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,

  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,

  // capture inputs from pins
  input wire logic [CHANNELS-1:0] capture_i,

  // timer status
  output logic [WIDTH-1:0] count_o,
  output logic update_event_o,
  output logic [CHANNELS-1:0] compare_match_o
);

  //////////////////////////////////////////////////////////////////////////
  // declarations

  tccr_bus_state_t state_q;
  tccr_bus_state_t state_d;
  logic [7:0] addr_q;
  logic addr_phase;
  logic word_access;
  logic wr_strobe;
  logic [31:0] rd_word;

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] divide_q;
  logic [WIDTH-1:0] reload_q;
  logic equal_skip_q;
  logic count_en_q;
  logic [CHANNELS-1:0] ch_input_q;
  logic [CHANNELS-1:0] ch_enable_q;
  logic [CHANNELS-1:0] ch_shadow_q;

  logic tick;
  logic update_evt;

  logic [CHANNELS-1:0] cap_meta_q;
  logic [CHANNELS-1:0] cap_sync_q;
  logic [CHANNELS-1:0] cap_last_q;
  logic [CHANNELS-1:0] cap_edge;

  logic [CHANNELS-1:0] ch_write;
  logic [CHANNELS-1:0] ch_match;
  logic [WIDTH-1:0] ch_value [CHANNELS];

  logic [31:0] hrdata_q;
  logic hreadyout_q;

  //////////////////////////////////////////////////////////////////////////
  // bus address phase

  assign word_access = (hsize_i == `TCCR_HSIZE_WORD);
  assign addr_phase = hsel_i && htrans_i[1] && hready_i && word_access;

  always_comb begin
    state_d = TCCR_ST_IDLE;
    if (addr_phase) begin
      state_d = hwrite_i ? TCCR_ST_WRITE : TCCR_ST_READ;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= TCCR_ST_IDLE;
    end else begin
      unique case (state_q)
        TCCR_ST_IDLE: begin
          state_q <= state_d;
        end
        TCCR_ST_WRITE: begin
          state_q <= state_d;
        end
        TCCR_ST_READ: begin
          // read data stands on the bus in the next cycle
          state_q <= hreadyout_q ? state_d : TCCR_ST_IDLE;
        end
        default: begin
          state_q <= TCCR_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= 8'h00;
    end else if (addr_phase) begin
      addr_q <= haddr_i[7:0];
    end
  end

  assign wr_strobe = (state_q == TCCR_ST_WRITE);

  //////////////////////////////////////////////////////////////////////////
  // bus answer: one wait state on reads, none on writes

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hreadyout_q <= 1'b1;
    end else if (state_q == TCCR_ST_READ && !hreadyout_q) begin
      hreadyout_q <= 1'b1;
    end else if (addr_phase && !hwrite_i) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_q <= `TCCR_RST_WORD;
    end else if (state_q == TCCR_ST_READ && !hreadyout_q) begin
      hrdata_q <= rd_word;
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hreadyout_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux, reserved bits read as zero

  always_comb begin
    rd_word = `TCCR_RST_WORD;
    unique case (addr_q)
      `TCCR_OFS_COUNTER: begin
        rd_word[WIDTH-1:0] = count_q;
      end
      `TCCR_OFS_PRESCALER: begin
        rd_word[WIDTH-1:0] = divide_q;
      end
      `TCCR_OFS_RELOAD: begin
        rd_word[WIDTH-1:0] = reload_q;
      end
      `TCCR_OFS_CH0_VALUE: begin
        rd_word[WIDTH-1:0] = ch_value[0];
      end
      `TCCR_OFS_CH1_VALUE: begin
        rd_word[WIDTH-1:0] = ch_value[1];
      end
      `TCCR_OFS_WR_FILTER: begin
        rd_word[`TCCR_BIT_EQUAL_SKIP] = equal_skip_q;
      end
      `TCCR_OFS_CHAN_CTRL: begin
        rd_word[`TCCR_BIT_COUNT_EN] = count_en_q;
        for (int i = 0; i < CHANNELS; i++) begin
          rd_word[i*`TCCR_CH_CTRL_STRIDE + `TCCR_BIT_CH_INPUT] = ch_input_q[i];
          rd_word[i*`TCCR_CH_CTRL_STRIDE + `TCCR_BIT_CH_ENABLE] =
            ch_enable_q[i];
          rd_word[i*`TCCR_CH_CTRL_STRIDE + `TCCR_BIT_CH_SHADOW] =
            ch_shadow_q[i];
        end
      end
      default: begin
        rd_word = `TCCR_RST_WORD;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // software written registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      divide_q <= `TCCR_RST_VALUE16;
    end else if (wr_strobe && addr_q == `TCCR_OFS_PRESCALER) begin
      divide_q <= hwdata_i[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_q <= `TCCR_RST_VALUE16;
    end else if (wr_strobe && addr_q == `TCCR_OFS_RELOAD) begin
      reload_q <= hwdata_i[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      equal_skip_q <= 1'b0;
    end else if (wr_strobe && addr_q == `TCCR_OFS_WR_FILTER) begin
      equal_skip_q <= hwdata_i[`TCCR_BIT_EQUAL_SKIP];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_en_q <= 1'b0;
    end else if (wr_strobe && addr_q == `TCCR_OFS_CHAN_CTRL) begin
      count_en_q <= hwdata_i[`TCCR_BIT_COUNT_EN];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counter

  tccr_prescaler #(
    .WIDTH(WIDTH)
  ) u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(count_en_q),
    .update_i(update_evt),
    .divide_i(divide_q),
    .tick_o(tick)
  );

  assign update_evt = tick && (count_q == reload_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= `TCCR_RST_VALUE16;
    end else if (wr_strobe && addr_q == `TCCR_OFS_COUNTER) begin
      count_q <= hwdata_i[WIDTH-1:0];
    end else if (update_evt) begin
      count_q <= '0;
    end else if (tick) begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= `TCCR_RST_VALUE16;
      update_event_o <= 1'b0;
      compare_match_o <= '0;
    end else begin
      count_o <= count_q;
      update_event_o <= update_evt;
      compare_match_o <= ch_match;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // capture input synchroniser and edge detect

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_meta_q <= '0;
      cap_sync_q <= '0;
      cap_last_q <= '0;
    end else begin
      cap_meta_q <= capture_i;
      cap_sync_q <= cap_meta_q;
      cap_last_q <= cap_sync_q;
    end
  end

  assign cap_edge = cap_sync_q & ~cap_last_q;

  //////////////////////////////////////////////////////////////////////////
  // channels

  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    localparam int BASE = g * `TCCR_CH_CTRL_STRIDE;
    localparam logic [7:0] OFS = (g == 0) ? `TCCR_OFS_CH0_VALUE :
      `TCCR_OFS_CH1_VALUE;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ch_input_q[g] <= 1'b0;
        ch_enable_q[g] <= 1'b0;
        ch_shadow_q[g] <= 1'b0;
      end else if (wr_strobe && addr_q == `TCCR_OFS_CHAN_CTRL) begin
        ch_input_q[g] <= hwdata_i[BASE + `TCCR_BIT_CH_INPUT];
        ch_enable_q[g] <= hwdata_i[BASE + `TCCR_BIT_CH_ENABLE];
        ch_shadow_q[g] <= hwdata_i[BASE + `TCCR_BIT_CH_SHADOW];
      end
    end

    assign ch_write[g] = wr_strobe && (addr_q == OFS);

    tccr_channel #(
      .WIDTH(WIDTH)
    ) u_channel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .input_mode_i(ch_input_q[g]),
      .enable_i(ch_enable_q[g]),
      .shadow_en_i(ch_shadow_q[g]),
      .equal_skip_i(equal_skip_q),
      .capture_i(cap_edge[g]),
      .update_i(update_evt),
      .write_i(ch_write[g]),
      .wdata_i(hwdata_i[WIDTH-1:0]),
      .count_i(count_q),
      .value_o(ch_value[g]),
      .match_o(ch_match[g])
    );
  end

endmodule
`default_nettype wire

// File: tccr_top_chk.sv
// checker of the timer register slice bus and counter ports
`timescale 1ns/10ps
`default_nettype none
module tccr_top_chk #(
  parameter int WIDTH = 16,
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // timer
  input wire logic [CHANNELS-1:0] capture_i,
  input wire logic [WIDTH-1:0] count_o,
  input wire logic update_event_o,
  input wire logic [CHANNELS-1:0] compare_match_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic acc;
  logic rd;
  logic wr;
  assign acc = hsel_i && htrans_i[1] && hready_i && hsize_i == 3'h2;
  assign rd = acc && !hwrite_i;
  assign wr = acc && hwrite_i;
  a_read_wait: assert property (rd |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read data phase length wrong");
  a_write_nowait: assert property (wr |=> hreadyout_o ##1
    (hreadyout_o || $past(rd))) else $error("write stalled");
  a_ready_cause: assert property (!hreadyout_o |-> $past(rd))
    else $error("wait state without read");
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property (!$past(rd) && !$past(rd, 2)
    |-> $stable(hrdata_o)) else $error("read data moved");
  a_count_step: assert property (!$past(wr) && !$past(wr, 2)
    && !$past(wr, 3) && count_o != $past(count_o)
    |-> count_o == $past(count_o) + 1'b1 || count_o == '0)
    else $error("count jumped");
  a_update_pulse: assert property (update_event_o && count_o != '0
    |=> !update_event_o) else $error("update not a pulse");
  a_rst_clear: assert property ($fell(rst_i) |-> count_o == '0
    && hrdata_o == 32'h0 && !update_event_o && hreadyout_o)
    else $error("outputs not cleared by reset");
  c_read: cover property (rd);
  c_update: cover property (update_event_o);
  c_match: cover property (compare_match_o[0]);
  c_match1: cover property (compare_match_o[1]);
endmodule
bind tccr_top tccr_top_chk #(.WIDTH(WIDTH), .CHANNELS(CHANNELS))
  u_tccr_top_chk (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .capture_i(capture_i), .count_o(count_o),
  .update_event_o(update_event_o), .compare_match_o(compare_match_o));
`default_nettype wire

// File: tccr_top_tb_top.sv
// self-checking testbench of the timer register slice
`timescale 1ns/10ps
`default_nettype none
`include "tccr_params.svh"
module tccr_top_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] cap = 2'h0;
  logic [31:0] hrdata;
  logic hready;
  logic upd;
  logic [15:0] cnt;
  logic [1:0] match;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  tccr_top u_tccr_top (.clk_i(clk), .rst_i(rst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
    .capture_i(cap), .count_o(cnt), .update_event_o(upd),
    .compare_match_o(match));
  task automatic chk(input logic [31:0] e, g, input string s);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, string s);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(e, q, s);
  endtask
  task automatic wait_upd(output int t);
    do @(posedge clk); while (upd !== 1'b1);
    t = cyc;
  endtask
  task automatic settle(input int ch, input logic e, input string s);
    repeat (4) @(posedge clk);
    chk({31'h0, e}, {31'h0, match[ch]}, s);
  endtask
  task automatic pulse(input int ch);
    cap[ch] <= 1'b1;
    repeat (3) @(posedge clk);
    cap[ch] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_reset;
    rdc(`TCCR_OFS_COUNTER, 32'h0, "cnt");
    rdc(`TCCR_OFS_PRESCALER, 32'h0, "psc");
    rdc(`TCCR_OFS_RELOAD, 32'h0, "reload");
    rdc(`TCCR_OFS_CH0_VALUE, 32'h0, "ch0");
    rdc(`TCCR_OFS_CH1_VALUE, 32'h0, "ch1");
    rdc(`TCCR_OFS_WR_FILTER, 32'h0, "filter");
    wr(8'h40, 32'h0000_1111);
    rdc(8'h40, 32'h0, "unmapped");
  endtask
  task automatic t_skip;
    wr(`TCCR_OFS_WR_FILTER, 32'h0000_0002);
    wr(`TCCR_OFS_CH1_VALUE, 32'h0000_00aa);
    wr(`TCCR_OFS_CH1_VALUE, 32'h0000_00aa);
    rdc(`TCCR_OFS_CH1_VALUE, 32'h0000_00aa, "ch1 same");
    wr(`TCCR_OFS_CH1_VALUE, 32'h0000_00bb);
    rdc(`TCCR_OFS_CH1_VALUE, 32'h0000_00bb, "ch1 new");
  endtask
  task automatic t_count;
    int t0;
    int t1;
    int t2;
    wr(`TCCR_OFS_COUNTER, 32'h0000_0123);
    rdc(`TCCR_OFS_COUNTER, 32'h0000_0123, "cnt wr");
    chk(32'h0000_0123, {16'h0, cnt}, "count_o");
    wr(`TCCR_OFS_RELOAD, 32'h0000_0009);
    rdc(`TCCR_OFS_RELOAD, 32'h0000_0009, "reload");
    wr(`TCCR_OFS_COUNTER, 32'h0);
    wr(`TCCR_OFS_CHAN_CTRL, 32'h0000_0100);
    wait_upd(t0);
    wr(`TCCR_OFS_PRESCALER, 32'h0000_0002);
    wait_upd(t1);
    wait_upd(t2);
    chk(32'd10, t1 - t0, "period old");
    chk(32'd30, t2 - t1, "period new");
    wr(`TCCR_OFS_CHAN_CTRL, 32'h0);
  endtask
  task automatic t_capture;
    wr(`TCCR_OFS_COUNTER, 32'h0000_0055);
    wr(`TCCR_OFS_CHAN_CTRL, 32'h0000_0013);
    pulse(0);
    pulse(1);
    rdc(`TCCR_OFS_CH0_VALUE, 32'h0000_0055, "ch0 cap");
    rdc(`TCCR_OFS_CH1_VALUE, 32'h0000_00bb, "ch1 off");
    wr(`TCCR_OFS_CH0_VALUE, 32'h0000_0077);
    rdc(`TCCR_OFS_CH0_VALUE, 32'h0000_0055, "ch0 ro");
    wr(`TCCR_OFS_COUNTER, 32'h0000_0066);
    wr(`TCCR_OFS_CHAN_CTRL, 32'h0000_0033);
    pulse(1);
    rdc(`TCCR_OFS_CH1_VALUE, 32'h0000_0066, "ch1 cap");
  endtask
  task automatic t_compare;
    int t;
    wr(`TCCR_OFS_CHAN_CTRL, 32'h0);
    wr(`TCCR_OFS_CH0_VALUE, 32'h0000_0005);
    wr(`TCCR_OFS_COUNTER, 32'h0000_0005);
    settle(0, 1'b1, "match eq");
    wr(`TCCR_OFS_COUNTER, 32'h0000_0006);
    settle(0, 1'b0, "match ne");
    wr(`TCCR_OFS_CH1_VALUE, 32'h0000_0006);
    settle(1, 1'b1, "match ch1");
    wr(`TCCR_OFS_CHAN_CTRL, 32'h0000_0004);
    wr(`TCCR_OFS_CH0_VALUE, 32'h0000_0009);
    wr(`TCCR_OFS_COUNTER, 32'h0000_0009);
    settle(0, 1'b0, "shadow old");
    wr(`TCCR_OFS_COUNTER, 32'h0);
    wr(`TCCR_OFS_CHAN_CTRL, 32'h0000_0104);
    wait_upd(t);
    wr(`TCCR_OFS_CHAN_CTRL, 32'h0000_0004);
    wr(`TCCR_OFS_COUNTER, 32'h0000_0009);
    settle(0, 1'b1, "shadow new");
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_skip;
    t_count;
    t_capture;
    t_compare;
    rdc(`TCCR_OFS_WR_FILTER, 32'h0000_0002, "skip bit");
    end_sim;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire
